/* bench/upt_monitor.sv */
/* upt_monitor: port-level assertions for upt_top.
   assumes one clock domain and a bind from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module upt_monitor import upt_pkg::*; (
	input wire logic CLK_IN, // clock
	input wire logic RST_N_IN, // async reset
	input wire logic [3:0] AVS_ADDRESS_IN, // address
	input wire logic AVS_READ_IN, // read
	input wire logic [31:0] AVS_READDATA_OUT, // read data
	input wire logic AVS_WAITREQUEST_OUT, // wait
	input wire logic SLEEP_REQ_IN, // sleep ask
	input wire logic SLEEP_BLOCK_OUT, // sleep block
	input wire logic USB_CLK_EN_OUT, // clock gate
	input wire logic XCVR_LOWPWR_OUT, // low power
	input wire logic ANALOG_EN_OUT, // analog on
	input wire logic PINS_OWNED_OUT, // pins owned
	input wire logic BUS_OPERATE_OUT, // operating
	input wire logic TOKEN_GO_OUT // token pulse
);
	// one domain, reset disables everything
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// read completing this cycle
	logic rd_done;
	assign rd_done = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
	// pins and analog follow the same enable
	property p_pins; PINS_OWNED_OUT == ANALOG_EN_OUT; endproperty
	a_pins: assert property (p_pins) else $error("pins and analog differ");
	// low power for a while means the clock is gated
	property p_gate; XCVR_LOWPWR_OUT [*3] |-> !USB_CLK_EN_OUT; endproperty
	a_gate: assert property (p_gate) else $error("clock runs in low power");
	// bus operation starts only with clock and transceiver up
	property p_wake; $rose(BUS_OPERATE_OUT) |-> USB_CLK_EN_OUT && !XCVR_LOWPWR_OUT; endproperty
	a_wake: assert property (p_wake) else $error("operate before power");
	// released pins mean no bus activity
	property p_off; !PINS_OWNED_OUT [*3] |-> !BUS_OPERATE_OUT && !TOKEN_GO_OUT; endproperty
	a_off: assert property (p_off) else $error("active while disabled");
	// token launch is one cycle, only while operating
	property p_go; TOKEN_GO_OUT |-> $past(BUS_OPERATE_OUT) ##1 !TOKEN_GO_OUT; endproperty
	a_go: assert property (p_go) else $error("bad token pulse");
	// block only follows a sleep request
	property p_sleep; SLEEP_BLOCK_OUT |-> $past(SLEEP_REQ_IN); endproperty
	a_sleep: assert property (p_sleep) else $error("block without request");
	// unmapped reads give zero
	property p_unmap; rd_done && AVS_ADDRESS_IN[1:0] != 2'h0 |-> AVS_READDATA_OUT == 32'h0000_0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	// frame high upper bits read zero
	property p_frm; rd_done && AVS_ADDRESS_IN == OFS_FRAME_HIGH |-> AVS_READDATA_OUT[31:3] == 29'h0; endproperty
	a_frm: assert property (p_frm) else $error("frame high spare bits set");
	// power control spare bits read zero
	property p_pwr;
		rd_done && AVS_ADDRESS_IN == OFS_POWER_CONTROL |-> (AVS_READDATA_OUT & 32'hFFFF_FF64) == 32'h0000_0000;
	endproperty
	a_pwr: assert property (p_pwr) else $error("power spare bits set");
endmodule // upt_monitor
`default_nettype wire

/* bench/upt_tb.sv */
/* testbench: register-level tests of upt_top with a usb partner.
   assumes the monitor bound below and a 200 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module testbench import upt_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic slp_req = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic [31:0] q;
	logic wreq, act, sof, blk, ck_en, lowpwr, ana, pins, op, go, irq;
	logic [10:0] frame;
	logic [1:0] kind;
	logic [3:0] ep;
	logic [3:0] codes [4] = '{TOK_SETUP, TOK_IN, TOK_OUT, TOK_IN};
	logic [1:0] kinds [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
	logic [10:0] frs [2] = '{11'h5A3, 11'h2FF};
	int err_count = 0;
	int n_checks = 0;
	// 5 ns clock
	always #2.5 clk = ~clk;
	upt_top uut (.CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
		.USB_ACTIVITY_IN(act), .USB_SOF_IN(sof), .USB_FRAME_IN(frame), .SLEEP_REQ_IN(slp_req),
		.SLEEP_BLOCK_OUT(blk), .USB_CLK_EN_OUT(ck_en), .XCVR_LOWPWR_OUT(lowpwr), .ANALOG_EN_OUT(ana),
		.PINS_OWNED_OUT(pins), .BUS_OPERATE_OUT(op), .TOKEN_GO_OUT(go), .TOKEN_KIND_OUT(kind),
		.TOKEN_EP_OUT(ep), .IRQ_OUT(irq));
	upt_usb_partner partner (.clk_in(clk), .act_out(act), .sof_out(sof), .frame_out(frame));
	// verdict and end of run
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// compare seen against expected
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// avalon transfer; held until waitrequest low, data taken at that edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 64) begin
			n++;
			@(posedge clk);
		end
		if (n == 64) begin
			err_count++;
			conclude();
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	// bounded wait for the operate level
	task automatic wait_op(input logic v);
		int n;
		for (n = 0; n < 200 && op !== v; n++)
			@(posedge clk);
		if (n == 200) begin
			err_count++;
			conclude();
		end
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("reset pins", {ana, pins, lowpwr}, 3'h1);
		bus(0, OFS_POWER_CONTROL, 0);
		chk("power rst", q, RST_POWER);
		bus(0, OFS_TOKEN_COMMAND, 0);
		chk("token rst", q, RST_TOKEN);
		bus(1, 4'h2, 32'hFFFF_FFFF);
		bus(0, 4'h2, 0);
		chk("unmapped", q, 0);
		// power up: busy during ramp, then operating
		bus(1, OFS_POWER_CONTROL, 32'h0000_0001);
		bus(0, OFS_POWER_CONTROL, 0);
		chk("busy up", q, 32'h0000_0009);
		wait_op(1);
		chk("up pins", {ck_en, ana, pins, lowpwr}, 4'hE);
		// two frames captured in turn, each read back after its sof
		for (int i = 0; i < 2; i++) begin
			partner.sof(frs[i]);
			bus(0, OFS_FRAME_HIGH, 0);
			chk("frame hi", q, {29'h0, frs[i][10:8]});
		end
		bus(0, OFS_IRQ_STATUS, 0);
		chk("sof evt", q, 32'h0000_0002);
		// sof interrupt unmasked, then cleared
		chk("irq idle", irq, 0);
		bus(1, OFS_IRQ_STATUS, 32'h0000_0200);
		chk("irq on", irq, 1);
		bus(1, OFS_IRQ_STATUS, 32'h0000_0202);
		chk("irq clr", irq, 0);
		// every token code, one repeated with a new endpoint
		for (int i = 0; i < 4; i++) begin
			bus(1, OFS_TOKEN_COMMAND, {24'h00_0000, codes[i], 4'(i + 3)});
			bus(0, OFS_TOKEN_COMMAND, 0);
			chk("token rd", q, {24'h00_0000, codes[i], 4'(i + 3)});
			chk("kind", kind, kinds[i]);
			chk("ep", ep, 4'(i + 3));
		end
		bus(0, OFS_IRQ_STATUS, 0);
		chk("token evt", q, 32'h0000_0204);
		// activity with its interrupt off stays pending
		partner.activity();
		bus(0, OFS_POWER_CONTROL, 0);
		chk("pending", q & 32'h0000_0080, 32'h0000_0080);
		bus(1, OFS_IRQ_STATUS, 32'h0000_0201);
		bus(0, OFS_POWER_CONTROL, 0);
		chk("no pend", q & 32'h0000_0080, 0);
		// guard blocks sleep on activity, not once cleared
		slp_req <= 1'b1;
		bus(1, OFS_POWER_CONTROL, 32'h0000_0011);
		partner.activity();
		repeat (3) @(posedge clk);
		chk("block", blk, 1);
		bus(1, OFS_POWER_CONTROL, 32'h0000_0001);
		chk("no block", blk, 0);
		// suspend gates clock, resume restores before operating
		bus(1, OFS_POWER_CONTROL, 32'h0000_0003);
		chk("suspend", {ck_en, lowpwr}, 2'h1);
		wait_op(0);
		bus(1, OFS_POWER_CONTROL, 32'h0000_0001);
		wait_op(1);
		chk("resume", {ck_en, lowpwr}, 2'h2);
		// disable releases pins, busy until settled
		bus(1, OFS_POWER_CONTROL, 0);
		chk("off", {ana, pins, lowpwr}, 3'h1);
		bus(0, OFS_POWER_CONTROL, 0);
		chk("busy dn", q & 32'h0000_0008, 32'h0000_0008);
		repeat (SETTLE_CYCLES + 4) @(posedge clk);
		bus(0, OFS_POWER_CONTROL, 0);
		chk("idle", q & 32'h0000_0008, 0);
		conclude();
	end
endmodule // testbench
bind upt_top upt_monitor u_mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
	.AVS_READ_IN(AVS_READ_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.SLEEP_REQ_IN(SLEEP_REQ_IN), .SLEEP_BLOCK_OUT(SLEEP_BLOCK_OUT), .USB_CLK_EN_OUT(USB_CLK_EN_OUT),
	.XCVR_LOWPWR_OUT(XCVR_LOWPWR_OUT), .ANALOG_EN_OUT(ANALOG_EN_OUT), .PINS_OWNED_OUT(PINS_OWNED_OUT),
	.BUS_OPERATE_OUT(BUS_OPERATE_OUT), .TOKEN_GO_OUT(TOKEN_GO_OUT));
`default_nettype wire

/* bench/upt_usb_partner.sv */
/* upt_usb_partner: usb bus side giving activity and sof with frame.
   assumes tasks are called just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module upt_usb_partner (
	input wire logic clk_in, // clock
	output logic act_out, // bus activity
	output logic sof_out, // sof pulse
	output logic [10:0] frame_out // frame number
);
	// idle lines at time zero
	initial begin
		act_out = 1'b0;
		sof_out = 1'b0;
		frame_out = 11'h000;
	end
	// one cycle of bus activity
	task automatic activity();
		@(posedge clk_in);
		act_out <= 1'b1;
		@(posedge clk_in);
		act_out <= 1'b0;
	endtask
	// sof with frame; frame lines turn over once it is gone
	task automatic sof(input logic [10:0] f);
		@(posedge clk_in);
		sof_out <= 1'b1;
		frame_out <= f;
		@(posedge clk_in);
		sof_out <= 1'b0;
		frame_out <= ~f;
	endtask
endmodule // upt_usb_partner
`default_nettype wire

/* design/upt_evt_if.sv */
/*
 * upt_evt_if: bundles the sticky event bits, their sets and their clears
 * between the top and the interrupt module. Single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface upt_evt_if;
	import upt_pkg::*;
	logic [IRQ_WIDTH-1:0] set_evt;
	logic [IRQ_WIDTH-1:0] clr_evt;
	logic [IRQ_WIDTH-1:0] mask;
	logic [IRQ_WIDTH-1:0] status;
	logic irq;
	modport ctrl (output set_evt, output clr_evt, output mask, input status, input irq);
	modport irqs (input set_evt, input clr_evt, input mask, output status, output irq);
endinterface : upt_evt_if
`default_nettype wire

/* design/upt_irq.sv */
/*
 * upt_irq: sticky event status with write-one-to-clear and a masked level
 * interrupt. Assumes clears come as one-cycle pulses from the bus slave.
 */
`timescale 1ns/1ps
`default_nettype none
module upt_irq import upt_pkg::*; (
	input wire logic clk_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	upt_evt_if.irqs evt // event set/clear/mask bundle
);
	logic [IRQ_WIDTH-1:0] status_ff;
	logic irq_ff;

	// per bit sticky flag, set wins over clear
	genvar i;
	for (i = 0; i < IRQ_WIDTH; i++) begin : g_bit
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				status_ff[i] <= 1'b0;
			end else if (evt.set_evt[i]) begin
				status_ff[i] <= 1'b1;
			end else if (evt.clr_evt[i]) begin
				status_ff[i] <= 1'b0;
			end
		end
	end

	// level interrupt from unmasked flags
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & evt.mask);
		end
	end

	assign evt.status = status_ff;
	assign evt.irq = irq_ff;
endmodule // upt_irq
`default_nettype wire

/* design/upt_pkg.sv */
/*
 * upt_pkg: register offsets, field positions, reset values, token codes
 * and timing counts for the usb power/token status block.
 * Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package upt_pkg;
	// register byte offsets
	localparam logic [3:0] OFS_POWER_CONTROL = 4'h0;
	localparam logic [3:0] OFS_FRAME_HIGH = 4'h4;
	localparam logic [3:0] OFS_TOKEN_COMMAND = 4'h8;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'hC;
	// power control fields
	localparam int BIT_ENABLE = 0;
	localparam int BIT_SUSPEND = 1;
	localparam int BIT_BUSY = 3;
	localparam int BIT_GUARD = 4;
	localparam int BIT_PENDING = 7;
	// irq status (low byte) and mask (bits 10:8) fields
	localparam int BIT_IRQ_ACTIVITY = 0;
	localparam int BIT_IRQ_SOF = 1;
	localparam int BIT_IRQ_TOKEN = 2;
	localparam int IRQ_MASK_LSB = 8;
	localparam int IRQ_WIDTH = 3;
	// token fields and codes
	localparam int TOK_TYPE_LSB = 4;
	localparam logic [3:0] TOK_SETUP = 4'b1101;
	localparam logic [3:0] TOK_IN = 4'b1001;
	localparam logic [3:0] TOK_OUT = 4'b0001;
	// reset values
	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_TOKEN = 8'h00;
	localparam logic [2:0] RST_FRAME = 3'h0;
	// settling time of the analog front end after enable/disable or wake
	localparam int SETTLE_NS = 100;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 5;
	// power sequencer states
	typedef enum logic [1:0] {PWR_OFF, PWR_RAMP_UP, PWR_ON, PWR_RAMP_DOWN} upt_pwr_t;
endpackage : upt_pkg

/* design/upt_sof_capture.sv */
/*
 * upt_sof_capture: latches the upper three frame number bits on each
 * received start-of-frame and reports a one-cycle event pulse.
 * Assumes sof strobe and frame number are synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module upt_sof_capture import upt_pkg::*; (
	input wire logic clk_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic sof_in, // start-of-frame received pulse
	input wire logic [10:0] frame_in, // frame number of that sof
	output logic [2:0] frame_upper_out, // captured upper bits
	output logic sof_evt_out // one-cycle capture pulse
);
	logic [2:0] frame_upper_ff;
	logic sof_evt_ff;

	// capture upper frame bits on sof
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_upper_ff <= RST_FRAME;
		end else if (sof_in) begin
			frame_upper_ff <= frame_in[10:8];
		end
	end

	// event pulse for the interrupt block
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sof_evt_ff <= 1'b0;
		end else begin
			sof_evt_ff <= sof_in;
		end
	end

	assign frame_upper_out = frame_upper_ff;
	assign sof_evt_out = sof_evt_ff;
endmodule // upt_sof_capture
`default_nettype wire

/* design/upt_top.sv */
/*
 * upt_top: power, suspend and status control of a usb module with its
 * frame number high and token registers, on an Avalon-MM slave.
 * Assumes the usb core gives synchronous activity, sof and frame inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module upt_top import upt_pkg::*; (
	input wire logic CLK_IN, // 200 MHz clock
	input wire logic RST_N_IN, // async reset, active low
	input wire logic [3:0] AVS_ADDRESS_IN, // byte address
	input wire logic AVS_READ_IN, // read request
	input wire logic AVS_WRITE_IN, // write request
	input wire logic [31:0] AVS_WRITEDATA_IN, // write data
	input wire logic [3:0] AVS_BYTEENABLE_IN, // byte lanes
	output logic [31:0] AVS_READDATA_OUT, // read data
	output logic AVS_WAITREQUEST_OUT, // wait request
	input wire logic USB_ACTIVITY_IN, // bus activity seen
	input wire logic USB_SOF_IN, // start-of-frame pulse
	input wire logic [10:0] USB_FRAME_IN, // frame number
	input wire logic SLEEP_REQ_IN, // system asks for sleep
	output logic SLEEP_BLOCK_OUT, // sleep entry blocked
	output logic USB_CLK_EN_OUT, // 48 MHz clock gate enable
	output logic XCVR_LOWPWR_OUT, // transceiver low power
	output logic ANALOG_EN_OUT, // analog features on
	output logic PINS_OWNED_OUT, // pins used by usb
	output logic BUS_OPERATE_OUT, // usb may drive the bus
	output logic TOKEN_GO_OUT, // token written pulse, only while operating
	output logic [1:0] TOKEN_KIND_OUT, // 1 setup 2 in 3 out
	output logic [3:0] TOKEN_EP_OUT, // token endpoint
	output logic IRQ_OUT // level interrupt
);
	logic enable_ff;
	logic suspend_ff;
	logic guard_ff;
	logic pending_ff;
	logic [7:0] token_ff;
	logic [IRQ_WIDTH-1:0] mask_ff;
	upt_pwr_t pwr_ff;
	upt_pwr_t nxt_pwr;
	logic [SETTLE_W-1:0] settle_ff;
	logic wake_ff;
	logic ack_ff;
	logic waitreq_ff;
	logic [31:0] rdata_ff;
	logic sleep_block_ff;
	logic clk_en_ff;
	logic lowpwr_ff;
	logic analog_ff;
	logic pins_ff;
	logic operate_ff;
	logic tok_go_ff;
	logic [1:0] tok_kind_ff;
	logic [2:0] frame_upper;
	logic sof_evt;
	logic req;
	logic wr_hit;
	logic rd_hit;
	logic busy;
	logic [31:0] rd_mux;
	upt_evt_if evt ();

	// one wait state: a request is answered the cycle after it appears
	assign req = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_ff;
	assign wr_hit = AVS_WRITE_IN & ~ack_ff & AVS_BYTEENABLE_IN[0];
	assign rd_hit = AVS_READ_IN & ~ack_ff;

	// bus handshake
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ack_ff <= 1'b0;
			waitreq_ff <= 1'b1;
		end else begin
			ack_ff <= req;
			waitreq_ff <= ~req; // registered inverted request, always the inverse of ack_ff in the same cycle
		end
	end

	// power control writable bits
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			enable_ff <= RST_POWER[BIT_ENABLE];
			suspend_ff <= RST_POWER[BIT_SUSPEND];
			guard_ff <= RST_POWER[BIT_GUARD];
		end else if (wr_hit && AVS_ADDRESS_IN == OFS_POWER_CONTROL) begin
			enable_ff <= AVS_WRITEDATA_IN[BIT_ENABLE];
			suspend_ff <= AVS_WRITEDATA_IN[BIT_SUSPEND];
			guard_ff <= AVS_WRITEDATA_IN[BIT_GUARD];
		end
	end

	// token register and its launch pulse
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			token_ff <= RST_TOKEN;
			tok_go_ff <= 1'b0;
		end else begin
			tok_go_ff <= 1'b0;
			if (wr_hit && AVS_ADDRESS_IN == OFS_TOKEN_COMMAND) begin
				token_ff <= AVS_WRITEDATA_IN[7:0];
				tok_go_ff <= operate_ff;
			end
		end
	end

	// decode token type into transaction kind
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			tok_kind_ff <= 2'd0;
		end else begin
			unique case (token_ff[TOK_TYPE_LSB +: 4])
				TOK_SETUP: tok_kind_ff <= 2'd1;
				TOK_IN: tok_kind_ff <= 2'd2;
				TOK_OUT: tok_kind_ff <= 2'd3;
				default: tok_kind_ff <= 2'd0; // reserved codes give kind 0, the go pulse still fires
			endcase
		end
	end

	// interrupt mask in bits 10:8 of the status register
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			mask_ff <= '0;
		end else if (AVS_WRITE_IN && !ack_ff && AVS_BYTEENABLE_IN[1] && AVS_ADDRESS_IN == OFS_IRQ_STATUS) begin
			mask_ff <= AVS_WRITEDATA_IN[IRQ_MASK_LSB +: IRQ_WIDTH];
		end
	end

	// event sets and write-one clears
	assign evt.set_evt = {tok_go_ff, sof_evt, USB_ACTIVITY_IN & enable_ff};
	assign evt.clr_evt = (wr_hit && AVS_ADDRESS_IN == OFS_IRQ_STATUS) ? AVS_WRITEDATA_IN[IRQ_WIDTH-1:0] : '0;
	assign evt.mask = mask_ff;

	// activity pending until its interrupt is unmasked or its status bit cleared
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pending_ff <= 1'b0;
		end else if (USB_ACTIVITY_IN && enable_ff && !mask_ff[BIT_IRQ_ACTIVITY]) begin
			pending_ff <= 1'b1;
		end else if (!evt.status[BIT_IRQ_ACTIVITY] || mask_ff[BIT_IRQ_ACTIVITY]) begin
			pending_ff <= 1'b0;
		end
	end

	// power sequencer next state
	always_comb begin
		nxt_pwr = pwr_ff;
		unique case (pwr_ff)
			PWR_OFF: if (enable_ff && !suspend_ff) nxt_pwr = PWR_RAMP_UP;
			PWR_RAMP_UP: if (!enable_ff) nxt_pwr = PWR_RAMP_DOWN;
				else if (settle_ff == SETTLE_W'(SETTLE_CYCLES - 1)) nxt_pwr = PWR_ON;
			PWR_ON: if (!enable_ff || suspend_ff) nxt_pwr = PWR_RAMP_DOWN;
			PWR_RAMP_DOWN: if (settle_ff == SETTLE_W'(SETTLE_CYCLES - 1)) nxt_pwr = PWR_OFF;
		endcase
	end

	// sequencer state and settle counter
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pwr_ff <= PWR_OFF;
			settle_ff <= '0;
		end else begin
			pwr_ff <= nxt_pwr;
			settle_ff <= (nxt_pwr != pwr_ff) ? '0 : settle_ff + SETTLE_W'(1);
		end
	end

	// registered enable-and-suspend state; only feeds unused_wake, drives nothing
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= enable_ff && suspend_ff;
		end
	end

	// busy while not fully off, except a ramp up whose enable was cleared
	assign busy = (pwr_ff != PWR_OFF) && !(pwr_ff == PWR_RAMP_UP && !enable_ff);

	// physical controls
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			clk_en_ff <= 1'b0;
			lowpwr_ff <= 1'b1;
			analog_ff <= 1'b0;
			pins_ff <= 1'b0;
			operate_ff <= 1'b0;
		end else begin
			clk_en_ff <= enable_ff && !suspend_ff;
			lowpwr_ff <= !enable_ff || suspend_ff;
			analog_ff <= enable_ff;
			pins_ff <= enable_ff;
			operate_ff <= (pwr_ff == PWR_ON) && (nxt_pwr == PWR_ON);
		end
	end

	// sleep guard
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sleep_block_ff <= 1'b0;
		end else begin
			sleep_block_ff <= guard_ff && SLEEP_REQ_IN && (USB_ACTIVITY_IN || pending_ff || |evt.status);
		end
	end

	// read mux, unimplemented bits are zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (AVS_ADDRESS_IN)
			OFS_POWER_CONTROL: begin
				rd_mux[BIT_ENABLE] = enable_ff;
				rd_mux[BIT_SUSPEND] = suspend_ff;
				rd_mux[BIT_BUSY] = busy;
				rd_mux[BIT_GUARD] = guard_ff;
				rd_mux[BIT_PENDING] = pending_ff;
			end
			OFS_FRAME_HIGH: rd_mux[2:0] = frame_upper;
			OFS_TOKEN_COMMAND: rd_mux[7:0] = token_ff;
			OFS_IRQ_STATUS: begin
				rd_mux[IRQ_WIDTH-1:0] = evt.status;
				rd_mux[IRQ_MASK_LSB +: IRQ_WIDTH] = mask_ff;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data register
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rdata_ff <= 32'h0000_0000;
		end else if (rd_hit) begin
			rdata_ff <= rd_mux;
		end
	end

	upt_sof_capture u_sof (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.sof_in(USB_SOF_IN & operate_ff),
		.frame_in(USB_FRAME_IN),
		.frame_upper_out(frame_upper),
		.sof_evt_out(sof_evt)
	);

	upt_irq u_irq (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.evt(evt)
	);

	// waitrequest high until the answer cycle
	assign AVS_WAITREQUEST_OUT = waitreq_ff;
	assign AVS_READDATA_OUT = rdata_ff;
	assign SLEEP_BLOCK_OUT = sleep_block_ff;
	assign USB_CLK_EN_OUT = clk_en_ff;
	assign XCVR_LOWPWR_OUT = lowpwr_ff;
	assign ANALOG_EN_OUT = analog_ff;
	assign PINS_OWNED_OUT = pins_ff;
	assign BUS_OPERATE_OUT = operate_ff;
	assign TOKEN_GO_OUT = tok_go_ff;
	assign TOKEN_KIND_OUT = tok_kind_ff;
	assign TOKEN_EP_OUT = token_ff[3:0];
	assign IRQ_OUT = evt.irq;
	logic unused_wake;
	assign unused_wake = wake_ff;
endmodule // upt_top
`default_nettype wire
